/* src/drrtc_cfg_if.sv */
// Interface carrying configuration from the register file to refresh and timing logic.
`timescale 1ns/1ns
interface drrtc_cfg_if;
   logic [15:0] row_type_map;
   logic [2:0] refresh_rate_select;
   logic [2:0] host_freq_select;
   logic refresh_queue_enable;
   logic edo_probe_mode;
   logic refresh_kind_select;
   logic rate_change;
   modport regs (output row_type_map, refresh_rate_select, host_freq_select,
      refresh_queue_enable, edo_probe_mode, refresh_kind_select, rate_change);
   modport user (input row_type_map, refresh_rate_select, host_freq_select,
      refresh_queue_enable, edo_probe_mode, refresh_kind_select, rate_change);
endinterface : drrtc_cfg_if

/* src/drrtc_pkg.sv */
// Package with register map, field positions, reset values and timing constants.
package drrtc_pkg;
   // Register byte offsets on the configuration port.
   localparam logic [7:0] OFF_ROW_TYPE_LO = 8'h55;
   localparam logic [7:0] OFF_ROW_TYPE_HI = 8'h56;
   localparam logic [7:0] OFF_MODE_REFRESH = 8'h57;
   localparam logic [7:0] OFF_CTRL_CONFIG = 8'h50;
   localparam logic [7:0] OFF_STATUS = 8'h5a;
   // Reset values.
   localparam logic [15:0] ROW_TYPE_RESET = 16'h0000;
   localparam logic [7:0] MODE_REFRESH_RESET = 8'h01;
   localparam logic [7:0] CTRL_CONFIG_RESET = 8'h00;
   localparam logic [7:0] MODE_REFRESH_MASK = 8'h77;
   // Field positions in the mode and refresh control register.
   localparam int QUEUE_EN_BIT = 6;
   localparam int EDO_PROBE_BIT = 5;
   localparam int REFRESH_KIND_BIT = 4;
   localparam int RATE_MSB = 2;
   // Host frequency select field in the controller configuration register.
   localparam int HOST_FREQ_MSB = 2;
   // Refresh rate codes.
   localparam logic [2:0] RATE_DISABLED = 3'h0;
   localparam logic [2:0] RATE_NORMAL = 3'h1;
   localparam logic [2:0] RATE_FAST = 3'h7;
   // Row memory types.
   typedef enum logic [1:0] {
      MEM_FPM = 2'h0,
      MEM_EDO = 2'h1,
      MEM_BEDO = 2'h2,
      MEM_EMPTY = 2'h3
   } drrtc_mem_e;
   // Fast refresh interval count in host clocks, queue depth, row count and timer width.
   localparam int FAST_INTERVAL = 32;
   localparam int QUEUE_DEPTH = 4;
   localparam int ROWS = 8;
   localparam int TIMER_W = 12;
   // Normal intervals per host frequency select code, 15.6 us at each bus rate.
   localparam logic [TIMER_W-1:0] NORMAL_IVL_50 = 12'h30c;
   localparam logic [TIMER_W-1:0] NORMAL_IVL_60 = 12'h3a8;
   localparam logic [TIMER_W-1:0] NORMAL_IVL_66 = 12'h410;
   localparam logic [TIMER_W-1:0] FAST_IVL = 12'h020;
endpackage : drrtc_pkg

/* src/drrtc_refresh.sv */
// Refresh request timer and four-deep refresh queue.
`timescale 1ns/1ns
module drrtc_refresh (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Configuration
   drrtc_cfg_if.user cfg,
   // Refresh service handshake
   input wire logic refresh_done,
   output logic refresh_pending,
   output logic refresh_priority,
   output logic [2:0] queue_count,
   output logic tick
);
   logic [drrtc_pkg::TIMER_W-1:0] timer_reg;
   logic [drrtc_pkg::TIMER_W-1:0] interval;
   logic [2:0] count_reg;
   logic [5:0] chk_gap_reg;
   logic chk_fast_reg;

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      unique case (cfg.host_freq_select)
         3'h0: interval = drrtc_pkg::NORMAL_IVL_60;
         3'h1: interval = drrtc_pkg::NORMAL_IVL_66;
         default: interval = drrtc_pkg::NORMAL_IVL_50;
      endcase
      if (cfg.refresh_rate_select == drrtc_pkg::RATE_FAST) begin
         interval = drrtc_pkg::FAST_IVL;
      end
   end

   // Ticks only for the normal and fast codes; under reserved codes the timer still counts but never ticks.
   // No tick while a restart is pending, so a stale count never fires at the new rate.
   assign tick = (cfg.refresh_rate_select == drrtc_pkg::RATE_NORMAL
      || cfg.refresh_rate_select == drrtc_pkg::RATE_FAST) && !cfg.rate_change
      && timer_reg == interval - 12'h001;

   always_ff @(posedge clk) begin
      if (reset || cfg.rate_change) begin
         timer_reg <= '0;
      end else if (tick) begin
         timer_reg <= '0;
      end else if (cfg.refresh_rate_select != drrtc_pkg::RATE_DISABLED) begin
         timer_reg <= timer_reg + 12'h001;
      end
   end

   // A new request and a completion in the same cycle cancel; the count holds.
   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= '0;
      end else if (tick && !refresh_done && count_reg < 3'(drrtc_pkg::QUEUE_DEPTH)) begin
         count_reg <= count_reg + 3'h1;
      end else if (!tick && refresh_done && count_reg != 3'h0) begin
         count_reg <= count_reg - 3'h1;
      end
   end

   assign queue_count = count_reg;
   assign refresh_pending = count_reg != 3'h0;
   // Disabled queue makes every request priority; enabled, only the fourth entry.
   assign refresh_priority = refresh_pending && (!cfg.refresh_queue_enable
      || count_reg == 3'(drrtc_pkg::QUEUE_DEPTH));

   // Checker helpers: cycles since the last tick, and whether that whole span ran at the
   // fast rate with no restart in it.
   always_ff @(posedge clk) begin
      if (reset || tick) begin
         chk_gap_reg <= 6'h00;
      end else if (chk_gap_reg != 6'h3f) begin
         chk_gap_reg <= chk_gap_reg + 6'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         chk_fast_reg <= 1'b0;
      end else if (tick) begin
         chk_fast_reg <= cfg.refresh_rate_select == drrtc_pkg::RATE_FAST && !cfg.rate_change;
      end else if (cfg.rate_change || cfg.refresh_rate_select != drrtc_pkg::RATE_FAST) begin
         chk_fast_reg <= 1'b0;
      end
   end

   a_fast_period: assert property (@(posedge clk) disable iff (reset)
      tick && chk_fast_reg && cfg.refresh_rate_select == drrtc_pkg::RATE_FAST
      |-> chk_gap_reg == 6'(drrtc_pkg::FAST_INTERVAL - 1))
      else $error("fast refresh not every 32 clocks");
   a_disabled_silent: assert property (@(posedge clk) disable iff (reset)
      cfg.refresh_rate_select == drrtc_pkg::RATE_DISABLED |-> !tick)
      else $error("refresh tick while disabled");
   a_unqueued_prio: assert property (@(posedge clk) disable iff (reset)
      !cfg.refresh_queue_enable && refresh_pending |-> refresh_priority)
      else $error("unqueued refresh not priority");
endmodule : drrtc_refresh

/* src/drrtc_top.sv */
// DRAM row type map and refresh control block with its register port.
`timescale 1ns/1ns
module drrtc_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // DRAM cycle request
   input wire logic CYCLE_START,
   input wire logic [2:0] CYCLE_ROW,
   input wire logic [1:0] READ_BURST_SEL,
   input wire logic [1:0] WRITE_BURST_SEL,
   input wire logic CYCLE_IS_WRITE,
   output logic [1:0] CYCLE_MEM_TYPE,
   output logic [1:0] CYCLE_BURST_RATE,
   output logic CYCLE_PROBE_TIMING,
   output logic CYCLE_VALID,
   // Refresh
   input wire logic REFRESH_DONE,
   output logic REFRESH_REQ,
   output logic REFRESH_PRIORITY,
   output logic REFRESH_RAS_ONLY
);
   drrtc_cfg_if cfg ();

   logic [15:0] row_type_reg;
   logic [7:0] mode_reg;
   logic [7:0] config_reg;
   logic rate_change_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic pending;
   logic priority_w;
   logic [2:0] qcount;
   logic [1:0] row_type_next;
   logic [1:0] burst_next;
   logic [1:0] mem_type_reg;
   logic [1:0] burst_reg;
   logic probe_reg;
   logic valid_reg;
   logic req_reg;
   logic prio_reg;
   logic ras_only_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.

   // Byte-wide port: each half of the row type register is its own byte.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         row_type_reg <= drrtc_pkg::ROW_TYPE_RESET;
      end else if (WR && ADDR == drrtc_pkg::OFF_ROW_TYPE_LO) begin
         row_type_reg[7:0] <= WDATA;
      end else if (WR && ADDR == drrtc_pkg::OFF_ROW_TYPE_HI) begin
         row_type_reg[15:8] <= WDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         mode_reg <= drrtc_pkg::MODE_REFRESH_RESET;
      end else if (WR && ADDR == drrtc_pkg::OFF_MODE_REFRESH) begin
         mode_reg <= WDATA & drrtc_pkg::MODE_REFRESH_MASK;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         config_reg <= drrtc_pkg::CTRL_CONFIG_RESET;
      end else if (WR && ADDR == drrtc_pkg::OFF_CTRL_CONFIG) begin
         config_reg <= WDATA;
      end
   end

   // Only a write that changes the rate code restarts the timer.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rate_change_reg <= 1'b0;
      end else begin
         rate_change_reg <= WR && ADDR == drrtc_pkg::OFF_MODE_REFRESH
            && WDATA[drrtc_pkg::RATE_MSB:0] != mode_reg[drrtc_pkg::RATE_MSB:0];
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      unique case (ADDR)
         drrtc_pkg::OFF_ROW_TYPE_LO: rdata_next = row_type_reg[7:0];
         drrtc_pkg::OFF_ROW_TYPE_HI: rdata_next = row_type_reg[15:8];
         drrtc_pkg::OFF_MODE_REFRESH: rdata_next = mode_reg;
         drrtc_pkg::OFF_CTRL_CONFIG: rdata_next = config_reg;
         drrtc_pkg::OFF_STATUS: rdata_next = {3'h0, prio_reg, req_reg, qcount};
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= RD ? rdata_next : 8'h00;
      end
   end

   assign cfg.row_type_map = row_type_reg;
   assign cfg.refresh_rate_select = mode_reg[drrtc_pkg::RATE_MSB:0];
   assign cfg.host_freq_select = config_reg[drrtc_pkg::HOST_FREQ_MSB:0];
   assign cfg.refresh_queue_enable = mode_reg[drrtc_pkg::QUEUE_EN_BIT];
   assign cfg.edo_probe_mode = mode_reg[drrtc_pkg::EDO_PROBE_BIT];
   assign cfg.refresh_kind_select = mode_reg[drrtc_pkg::REFRESH_KIND_BIT];
   assign cfg.rate_change = rate_change_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Refresh engine.

   drrtc_refresh u_refresh (
      .clk(CLK),
      .reset(RESET),
      .cfg(cfg),
      .refresh_done(REFRESH_DONE),
      .refresh_pending(pending),
      .refresh_priority(priority_w),
      .queue_count(qcount),
      .tick()
   );

   always_ff @(posedge CLK) begin
      if (RESET) begin
         req_reg <= 1'b0;
         prio_reg <= 1'b0;
         ras_only_reg <= 1'b0;
      end else begin
         req_reg <= pending;
         prio_reg <= priority_w;
         ras_only_reg <= cfg.refresh_kind_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-cycle timing selection.

   assign row_type_next = row_type_reg[{CYCLE_ROW, 1'b0} +: 2];

   // Burst rate code: 0 x444, 1 x333, 2 x322, 3 x222; code 3 on reads means reserved.
   always_comb begin
      burst_next = 2'h0;
      if (CYCLE_IS_WRITE) begin
         unique case (row_type_next)
            drrtc_pkg::MEM_FPM: burst_next = (WRITE_BURST_SEL[1]) ? 2'h1 : 2'h0;
            default: burst_next = (WRITE_BURST_SEL == 2'h3) ? 2'h3
               : (WRITE_BURST_SEL == 2'h0) ? 2'h0 : 2'h1;
         endcase
      end else begin
         unique case (row_type_next)
            drrtc_pkg::MEM_FPM: burst_next = (READ_BURST_SEL == 2'h2) ? 2'h1 : 2'h0;
            drrtc_pkg::MEM_EDO: burst_next = (READ_BURST_SEL == 2'h2) ? 2'h2
               : (READ_BURST_SEL == 2'h1) ? 2'h1 : 2'h0;
            default: burst_next = (READ_BURST_SEL == 2'h0) ? 2'h1 : 2'h3;
         endcase
      end
   end

   // Empty rows never start a cycle.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         mem_type_reg <= 2'h0;
         burst_reg <= 2'h0;
         probe_reg <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         mem_type_reg <= row_type_next;
         burst_reg <= burst_next;
         probe_reg <= CYCLE_START && cfg.edo_probe_mode;
         valid_reg <= CYCLE_START && row_type_next != drrtc_pkg::MEM_EMPTY;
      end
   end

   assign RDATA = rdata_reg;
   assign CYCLE_MEM_TYPE = mem_type_reg;
   assign CYCLE_BURST_RATE = burst_reg;
   assign CYCLE_PROBE_TIMING = probe_reg;
   assign CYCLE_VALID = valid_reg;
   assign REFRESH_REQ = req_reg;
   assign REFRESH_PRIORITY = prio_reg;
   assign REFRESH_RAS_ONLY = ras_only_reg;

   a_row_type_sel: assert property (@(posedge CLK) disable iff (RESET)
      CYCLE_START |=> CYCLE_MEM_TYPE == $past(row_type_reg[{CYCLE_ROW, 1'b0} +: 2]))
      else $error("cycle type not from targeted row");
   a_empty_row: assert property (@(posedge CLK) disable iff (RESET)
      CYCLE_START && row_type_next == drrtc_pkg::MEM_EMPTY |=> !CYCLE_VALID)
      else $error("cycle started on empty row");
   a_rate_restart: assert property (@(posedge CLK) disable iff (RESET)
      WR && ADDR == drrtc_pkg::OFF_MODE_REFRESH && WDATA[2:0] != mode_reg[2:0]
      |=> rate_change_reg)
      else $error("rate change did not restart timer");
   a_kind_follow: assert property (@(posedge CLK) disable iff (RESET)
      ##1 REFRESH_RAS_ONLY == $past(mode_reg[drrtc_pkg::REFRESH_KIND_BIT]))
      else $error("refresh kind not following bit");
   a_probe_timing: assert property (@(posedge CLK) disable iff (RESET)
      CYCLE_START && mode_reg[drrtc_pkg::EDO_PROBE_BIT] |=> CYCLE_PROBE_TIMING)
      else $error("probe timing not applied");
   a_byte_write: assert property (@(posedge CLK) disable iff (RESET)
      WR && ADDR == drrtc_pkg::OFF_ROW_TYPE_HI |=> row_type_reg[7:0] == $past(row_type_reg[7:0]))
      else $error("high byte write disturbed low byte");
   a_fpm_read_burst: assert property (@(posedge CLK) disable iff (RESET)
      CYCLE_START && !CYCLE_IS_WRITE && row_type_next == drrtc_pkg::MEM_FPM
      && READ_BURST_SEL == 2'h0 |=> CYCLE_BURST_RATE == 2'h0)
      else $error("page mode read burst wrong");
endmodule : drrtc_top

/* verification/drrtc_refresh_svc.sv */
// Behavioural refresh servicer that answers refresh requests with done pulses.
`timescale 1ns/1ns
module drrtc_refresh_svc (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bench control
   input wire logic enable,
   input wire logic slow,
   // Refresh handshake
   input wire logic refresh_req,
   output logic refresh_done
);
   logic [2:0] gap_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // The request lags the queue by one cycle, so a gap after each pulse avoids a double service.
   always_ff @(posedge clk) begin
      if (reset) begin
         refresh_done <= 1'b0;
         gap_reg <= 3'h0;
      end else if (refresh_done) begin
         refresh_done <= 1'b0;
         gap_reg <= slow ? 3'h7 : 3'h3;
      end else if (gap_reg != 3'h0) begin
         gap_reg <= gap_reg - 3'h1;
      end else begin
         refresh_done <= enable & refresh_req;
      end
   end
endmodule : drrtc_refresh_svc

/* verification/drrtc_top_tb.sv */
// Self-checking testbench for the row type map and refresh control block.
`timescale 1ns/1ns
module drrtc_top_tb;
   logic CLK, RESET, WR, RD, CYCLE_START, CYCLE_IS_WRITE, REFRESH_DONE;
   logic [7:0] ADDR, WDATA, RDATA, rb;
   logic [2:0] CYCLE_ROW;
   logic [1:0] READ_BURST_SEL, WRITE_BURST_SEL, CYCLE_MEM_TYPE, CYCLE_BURST_RATE;
   logic CYCLE_PROBE_TIMING, CYCLE_VALID, REFRESH_REQ, REFRESH_PRIORITY, REFRESH_RAS_ONLY;
   logic svc_en, svc_slow, seen_req;
   logic [15:0] map;
   logic [31:0] seed, r32;
   int failures, comparisons, cyc_n, tw, t0, t1, d0;
   drrtc_top drrtc_top_i (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .CYCLE_START(CYCLE_START), .CYCLE_ROW(CYCLE_ROW),
      .READ_BURST_SEL(READ_BURST_SEL), .WRITE_BURST_SEL(WRITE_BURST_SEL),
      .CYCLE_IS_WRITE(CYCLE_IS_WRITE), .CYCLE_MEM_TYPE(CYCLE_MEM_TYPE),
      .CYCLE_BURST_RATE(CYCLE_BURST_RATE), .CYCLE_PROBE_TIMING(CYCLE_PROBE_TIMING),
      .CYCLE_VALID(CYCLE_VALID), .REFRESH_DONE(REFRESH_DONE), .REFRESH_REQ(REFRESH_REQ),
      .REFRESH_PRIORITY(REFRESH_PRIORITY), .REFRESH_RAS_ONLY(REFRESH_RAS_ONLY));
   drrtc_refresh_svc drrtc_refresh_svc_i (.clk(CLK), .reset(RESET), .enable(svc_en),
      .slow(svc_slow), .refresh_req(REFRESH_REQ), .refresh_done(REFRESH_DONE));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // The ceiling is well above the roughly six thousand three hundred cycles the tests need.
   always @(posedge CLK) begin
      cyc_n <= cyc_n + 1;
      if (REFRESH_REQ === 1'b1) seen_req <= 1'b1;
      if (cyc_n == 20000) begin
         failures++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [1:0] exp_burst(logic [1:0] t, logic [1:0] s, logic w);
      if (w) return (t == 2'h0) ? {1'b0, s[1]} : (s == 2'h3) ? 2'h3 : {1'b0, s != 2'h0};
      if (t == 2'h2) return (s == 2'h0) ? 2'h1 : 2'h3;
      if (t == 2'h1) return s;
      return {1'b0, s == 2'h2};
   endfunction : exp_burst
   task automatic chk_val(string n, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk_val
   task automatic chk_time(string n, int e, int g);
      comparisons++;
      if (g != e) begin
         failures++;
         $display("wrong value %s expected %0d seen %0d", n, e, g);
      end
   endtask : chk_time
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
      tw = cyc_n;
   endtask : wr
   task automatic rd(logic [7:0] a);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      rb = RDATA;
   endtask : rd
   task automatic cyc(logic [2:0] r, logic [1:0] sel, logic w, logic pr);
      logic [1:0] t;
      logic [1:0] s;
      t = map[2*r +: 2];
      s = (!w && sel == 2'h3) ? 2'h2 : sel;
      @(posedge CLK);
      CYCLE_START <= 1'b1;
      CYCLE_ROW <= r;
      READ_BURST_SEL <= s;
      WRITE_BURST_SEL <= s;
      CYCLE_IS_WRITE <= w;
      @(posedge CLK);
      CYCLE_START <= 1'b0;
      #1;
      chk_val("mem type", t, CYCLE_MEM_TYPE);
      chk_val("valid", t != 2'h3, CYCLE_VALID);
      chk_val("probe", pr, CYCLE_PROBE_TIMING);
      if (t != 2'h3) chk_val("burst rate", exp_burst(t, s, w), CYCLE_BURST_RATE);
   endtask : cyc
   task automatic wait_rise(output int t);
      int k;
      k = 0;
      while (REFRESH_REQ !== 1'b0 && k < 1200) begin
         @(posedge CLK);
         #1;
         k++;
      end
      while (REFRESH_REQ !== 1'b1 && k < 2400) begin
         @(posedge CLK);
         #1;
         k++;
      end
      t = cyc_n;
   endtask : wait_rise
   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h00011e13;
      {WR, RD, CYCLE_START, CYCLE_IS_WRITE, svc_en, svc_slow, seen_req} = 7'h00;
      {ADDR, WDATA, CYCLE_ROW, READ_BURST_SEL, WRITE_BURST_SEL} = 23'h000000;
      {failures, comparisons, cyc_n} = 0;
      map = 16'h0000;
      RESET = 1'b1;
      repeat (4) @(posedge CLK);
      RESET <= 1'b0;
      rd(drrtc_pkg::OFF_ROW_TYPE_LO);
      chk_val("row type lo", 8'h00, rb);
      rd(drrtc_pkg::OFF_ROW_TYPE_HI);
      chk_val("row type hi", 8'h00, rb);
      rd(drrtc_pkg::OFF_MODE_REFRESH);
      chk_val("mode reset", 8'h01, rb);
      rd(8'h60);
      chk_val("unmapped", 8'h00, rb);
      wr(drrtc_pkg::OFF_MODE_REFRESH, 8'hff);
      rd(drrtc_pkg::OFF_MODE_REFRESH);
      chk_val("mode mask", 8'h77, rb);
      $display("register reset test done");
      for (int p = 0; p < 3; p++) begin
         r32 = rnd();
         map = (p == 0) ? 16'h1be4 : r32[15:0];
         wr(drrtc_pkg::OFF_ROW_TYPE_LO, map[7:0]);
         wr(drrtc_pkg::OFF_ROW_TYPE_HI, map[15:8]);
         wr(drrtc_pkg::OFF_MODE_REFRESH, {2'h0, p[0], p[0], 4'h0});
         rd(drrtc_pkg::OFF_ROW_TYPE_LO);
         chk_val("row type lo", map[7:0], rb);
         rd(drrtc_pkg::OFF_ROW_TYPE_HI);
         chk_val("row type hi", map[15:8], rb);
         chk_val("ras only", p[0], REFRESH_RAS_ONLY);
         for (int r = 0; r < 8; r++) begin
            r32 = rnd();
            cyc(r[2:0], r32[3:2], r32[1], p[0]);
         end
      end
      $display("row type test done");
      svc_en <= 1'b1;
      wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h07);
      t0 = tw;
      wait_rise(t1);
      d0 = t1 - t0;
      chk_val("priority", 1'b1, REFRESH_PRIORITY);
      t0 = t1;
      wait_rise(t1);
      chk_time("fast gap", 32, t1 - t0);
      r32 = rnd();
      repeat (r32[3:0] + 3) @(posedge CLK);
      wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h01);
      wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h07);
      t0 = tw;
      wait_rise(t1);
      chk_time("restart delay", d0, t1 - t0);
      wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h00);
      repeat (10) @(posedge CLK);
      seen_req <= 1'b0;
      repeat (300) @(posedge CLK);
      chk_val("no refresh", 1'b0, seen_req);
      $display("fast and disabled refresh test done");
      for (int h = 0; h < 3; h++) begin
         wr(drrtc_pkg::OFF_CTRL_CONFIG, h[7:0]);
         wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h01);
         wait_rise(t0);
         wait_rise(t1);
         d0 = (h == 0) ? int'(drrtc_pkg::NORMAL_IVL_60) :
            (h == 1) ? int'(drrtc_pkg::NORMAL_IVL_66) : int'(drrtc_pkg::NORMAL_IVL_50);
         chk_time("normal gap", d0, t1 - t0);
         wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h00);
      end
      $display("normal refresh test done");
      svc_en <= 1'b0;
      wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h47);
      wait_rise(t0);
      chk_val("priority", 1'b0, REFRESH_PRIORITY);
      repeat (140) @(posedge CLK);
      rd(drrtc_pkg::OFF_STATUS);
      chk_val("full queue", 8'h1c, rb);
      svc_slow <= 1'b1;
      svc_en <= 1'b1;
      wr(drrtc_pkg::OFF_MODE_REFRESH, 8'h40);
      repeat (60) @(posedge CLK);
      rd(drrtc_pkg::OFF_STATUS);
      chk_val("drained queue", 8'h00, rb);
      $display("refresh queue test done");
      end_of_test();
   end
endmodule : drrtc_top_tb
